//--- hdl/disk_tag_pkg.sv
// Constants, register map and types for the drive tag and sector logic.
// How it works
// [RULE1] Bus bits valid only while control tag
// [RULE2] Bit 0 write driver, bit 1 read
// [RULE3] Controller raises read window within 6 us
// [RULE4] Physical offset follows bits 2 and 3
// [RULE5] Controller waits 4 ms after offset
// [RULE6] Controller avoids writing while offset held
// [RULE7] Dummy offset only mimics status timing
// [RULE8] Cartridge write during offset sets fault
// [RULE9] Embedded offset toggle drops on-track 2 ms
// [RULE10] Fault clear 100 ns, only if gone
// [RULE11] Embedded fault clear needs 300 ns
// [RULE12] Mark gap write erases, suppresses write fault
// [RULE13] Mark gap read reports gap over 16 bits
// [RULE14] Controller holds bit 5 low if unused
// [RULE15] Recalibrate pulse 250 ns to 1 ms; on the embedded variant the code requires at least 300 ns
// [RULE16] Embedded recalibrate: head zero, 500 ms, off-track
// [RULE17] Bits 7 and 8 shift strobe while reading
// [RULE18] Bit 9 clears both reserves
// [RULE19] Reserve timer frees drive after 500 ms
// [RULE20] Select reserves; release honoured after 500 ns
// [RULE21] Priority select suppresses opposite channel entirely
// [RULE22] Sector spans preset plus one clocks
// [RULE23] Each servo clock equals 12 bits
// [RULE24] Cartridge and embedded give 63 sectors
// [RULE25] Cartridge volume change suppresses sectors until index
// [RULE26] Pulse widths checked by counting clock cycles
package disk_tag_pkg;

  localparam int CLK_PERIOD_NS = 50;

  // ==========================================================
  // Timing figures
  localparam int FCLR_MIN_NS      = 100;
  localparam int FCLR_EMB_MIN_NS  = 300;
  localparam int RECAL_MIN_NS     = 250;
  localparam int RECAL_MAX_NS     = 1000000;
  localparam int RELEASE_MIN_NS   = 500;
  localparam int OFFSET_HOLD_US   = 2750;
  localparam int EMB_HOLD_US      = 2000;
  localparam int RESERVE_HOLD_MS  = 500;
  localparam int RECAL_LIMIT_MS   = 500;

  localparam int FCLR_MIN_CYC     = (FCLR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FCLR_EMB_MIN_CYC = (FCLR_EMB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECAL_MIN_CYC    = (RECAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECAL_MAX_CYC    = RECAL_MAX_NS / CLK_PERIOD_NS;
  localparam int RELEASE_MIN_CYC  = (RELEASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFFSET_HOLD_CYC  = OFFSET_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam int EMB_HOLD_CYC     = EMB_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam int RESERVE_HOLD_CYC = RESERVE_HOLD_MS * 20000;
  localparam int RECAL_LIMIT_CYC  = RECAL_LIMIT_MS * 20000;

  // ==========================================================
  // Sector and mark constants
  localparam int SECTOR_PRESET_W  = 12;
  localparam int SECTORS_PER_REV  = 63;
  localparam int BITS_PER_SCLK    = 12;
  localparam int MARK_GAP_BITS    = 16;
  localparam int MARK_GAP_SCLK    = MARK_GAP_BITS / BITS_PER_SCLK + 1;

  // ==========================================================
  // Register map (byte addresses) and reset values
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_PRESET  = 4'h4;
  localparam logic [3:0]  ADDR_STATUS  = 4'h8;
  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam logic [11:0] PRESET_RESET = 12'hD28;
  localparam int CTRL_VARIANT_LSB = 0;
  localparam int CTRL_TIMER_BIT   = 2;
  localparam int CTRL_DUAL_BIT    = 3;

  typedef enum logic [1:0] {
    VAR_PHYSICAL  = 2'b00,
    VAR_DUMMY     = 2'b01,
    VAR_CARTRIDGE = 2'b11,
    VAR_EMBEDDED  = 2'b10
  } variant_type;

  typedef enum logic [1:0] {
    OWN_NONE = 2'b00,
    OWN_A    = 2'b01,
    OWN_B    = 2'b11
  } owner_type;

endpackage : disk_tag_pkg

//--- hdl/timer_if.sv
// Start/load/busy carrier between the main block and its interval timers.
`timescale 1ns/1ps
interface timer_if #(parameter int W = 24);
  logic         start;
  logic [W-1:0] load;
  logic         busy;
  modport ctl (output start, output load, input busy);
  modport tmr (input start, input load, output busy);
endinterface : timer_if

//--- hdl/interval_timer.sv
// Loadable down-counting interval timer.
`timescale 1ns/1ps
module interval_timer #(
  parameter int W = 24
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  timer_if.tmr     t
);
  logic [W-1:0] cnt_q;

  // A start while running restarts the interval.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (t.start) begin
      cnt_q <= t.load;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign t.busy = (cnt_q != '0);
endmodule : interval_timer

//--- hdl/pulse_qualifier.sv
// Measures a high pulse in clock cycles and flags in-range widths.
`timescale 1ns/1ps
module pulse_qualifier #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         level,
  input  wire logic [W-1:0] min_cycles,
  input  wire logic [W-1:0] max_cycles,
  output logic              reached,
  output logic              ended
);
  logic [W-1:0] width_q;
  logic         level_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      width_q <= '0;
      level_q <= 1'b0;
    end else begin
      level_q <= level;
      if (!level) begin
        width_q <= '0;
      end else if (width_q != '1) begin
        width_q <= width_q + 1'b1;
      end
    end
  end

  // [RULE26] width counted in cycles
  assign reached = level && (width_q == min_cycles - 1'b1);
  // A zero maximum means no upper bound, even at saturation; with a nonzero maximum saturation counts as too long.
  assign ended = level_q && !level && (width_q >= min_cycles) &&
                 ((max_cycles == '0) || ((width_q <= max_cycles) && (width_q != '1)));
endmodule : pulse_qualifier

//--- hdl/disk_tag_logic.sv
// Drive-side control tag decoder, fault, recalibrate, reservation and sector logic.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module disk_tag_logic
  import disk_tag_pkg::*;
#(
  parameter int OFFSET_HOLD  = OFFSET_HOLD_CYC,
  parameter int EMB_HOLD     = EMB_HOLD_CYC,
  parameter int RESERVE_HOLD = RESERVE_HOLD_CYC,
  parameter int RECAL_LIMIT  = RECAL_LIMIT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        control_select,
  input  wire logic [9:0]  bus_bits,
  input  wire logic        index_pin,
  input  wire logic        servo_clk_pin,
  input  wire logic        volume_change_tag,
  input  wire logic        select_a,
  input  wire logic        select_b,
  input  wire logic        priority_a,
  input  wire logic        priority_b,
  input  wire logic        enable_a,
  input  wire logic        enable_b,
  input  wire logic        fault_condition,
  input  wire logic        write_fault_condition,
  input  wire logic        read_signal_present,
  input  wire logic        home_reached,
  output logic             write_enable,
  output logic             read_enable,
  output logic             read_sync_start,
  output logic             offset_toward_spindle,
  output logic             offset_away_spindle,
  output logic             on_track,
  output logic             fault,
  output logic             write_fault,
  output logic             mark_erase,
  output logic             mark_found,
  output logic             strobe_early,
  output logic             strobe_late,
  output logic             recalibrate_home,
  output logic             head_reset,
  output logic             volume_select,
  output logic             seek_error_clear,
  output logic             unit_selected_a,
  output logic             unit_selected_b,
  output logic             busy_a,
  output logic             busy_b,
  output logic             sector_pulse
);

  // ==========================================================
  // Pin synchronisers
  localparam int NPIN = 24;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] sync_q;
  logic [NPIN-1:0] last_q;

  assign pin_raw = {control_select, bus_bits, index_pin, servo_clk_pin, volume_change_tag,
                    select_a, select_b, priority_a, priority_b, enable_a, enable_b,
                    fault_condition, write_fault_condition, read_signal_present, home_reached};

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  logic       s_tag;
  logic [9:0] s_bus;
  logic       s_index;
  logic       s_sclk;
  logic       s_vol;
  logic       s_sel_a;
  logic       s_sel_b;
  logic       s_pri_a;
  logic       s_pri_b;
  logic       s_en_a;
  logic       s_en_b;
  logic       s_fcond;
  logic       s_wfcond;
  logic       s_rdsig;
  logic       s_home;
  assign {s_tag, s_bus, s_index, s_sclk, s_vol, s_sel_a, s_sel_b, s_pri_a, s_pri_b,
          s_en_a, s_en_b, s_fcond, s_wfcond, s_rdsig, s_home} = sync_q;

  logic index_edge;
  logic sclk_edge;
  logic vol_edge;
  assign index_edge = sync_q[12] && !last_q[12];
  assign sclk_edge  = sync_q[11] && !last_q[11];
  assign vol_edge   = sync_q[10] && !last_q[10];

  // ==========================================================
  // Avalon-MM slave
  logic [3:0]             ctrl_q;
  logic [SECTOR_PRESET_W-1:0] preset_q;
  logic                   ack_q;
  logic [31:0]            status_word;
  variant_type            variant;
  logic                   timer_en;
  logic                   dual_chan;

  assign variant   = variant_type'(ctrl_q[CTRL_VARIANT_LSB +: 2]);
  assign timer_en  = ctrl_q[CTRL_TIMER_BIT];
  assign dual_chan = ctrl_q[CTRL_DUAL_BIT];
  // Every access is answered one cycle after it is presented.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_q        <= 1'b0;
      ctrl_q       <= CTRL_RESET;
      preset_q     <= PRESET_RESET;
      avs_readdata <= '0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      if (avs_write && ack_q) begin
        if (avs_address == ADDR_CTRL) begin
          ctrl_q <= avs_writedata[3:0];
        end
        if (avs_address == ADDR_PRESET) begin
          preset_q <= avs_writedata[SECTOR_PRESET_W-1:0];
        end
      end
      if (avs_read && !ack_q) begin
        case (avs_address)
          ADDR_CTRL:   avs_readdata <= {28'h0, ctrl_q};
          ADDR_PRESET: avs_readdata <= {20'h0, preset_q};
          ADDR_STATUS: avs_readdata <= status_word;
          default:     avs_readdata <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Control tag decode
  logic [9:0] ctl;
  logic       rd_q;
  logic       fault_q;
  logic       wfault_q;
  // [RULE1] bits gated by tag
  assign ctl = s_tag ? s_bus : 10'h000;

  logic erase_now;
  // [RULE12] write plus mark erases
  assign erase_now = ctl[0] && ctl[5] && (variant != VAR_EMBEDDED);

  // ==========================================================
  // Offset handling and on-track status
  logic [1:0]  off_last_q;
  logic        off_rise;
  logic        off_toggle;
  logic        recal_busy_q;
  timer_if #(.W(24)) hold_t ();
  interval_timer #(.W(24)) u_hold (.ref_clk(ref_clk), .rst_b(rst_b), .t(hold_t));

  assign off_toggle = (ctl[3:2] != off_last_q);
  assign off_rise   = |(ctl[3:2] & ~off_last_q);
  // [RULE9] embedded toggle drops on-track
  // [RULE7] dummy offset repeats status timing
  assign hold_t.start = (variant == VAR_EMBEDDED) ? off_toggle : off_rise;
  assign hold_t.load  = (variant == VAR_EMBEDDED) ? 24'(EMB_HOLD) : 24'(OFFSET_HOLD);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      off_last_q <= 2'b00;
    end else begin
      off_last_q <= ctl[3:2];
    end
  end

  // ==========================================================
  // Fault latch
  logic fclr_ok;
  logic [15:0] fclr_min;
  logic cart_offset_write;
  assign fclr_min = (variant == VAR_EMBEDDED) ? 16'(FCLR_EMB_MIN_CYC) : 16'(FCLR_MIN_CYC);
  // [RULE11] longer minimum on embedded
  pulse_qualifier #(.W(16)) u_fclr (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .level      (ctl[4]),
    .min_cycles (fclr_min),
    .max_cycles (16'h0000),
    .reached    (fclr_ok),
    .ended      ()
  );

  // [RULE8] cartridge write during offset
  assign cart_offset_write = (variant == VAR_CARTRIDGE) && ctl[0] && (|ctl[3:2]);

  // Set terms win over a clear arriving in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fault_q  <= 1'b0;
      wfault_q <= 1'b0;
    end else begin
      // [RULE10] clear only if cause gone
      if (fclr_ok && !s_fcond) begin
        fault_q  <= 1'b0;
        wfault_q <= 1'b0;
      end
      // [RULE12] write fault check suppressed
      if (cart_offset_write || (s_wfcond && ctl[0] && !erase_now)) begin
        fault_q  <= 1'b1;
        wfault_q <= 1'b1;
      end else if (s_fcond) begin
        fault_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Recalibrate to track zero
  logic recal_go;
  logic [15:0] recal_min;
  timer_if #(.W(24)) recal_t ();
  interval_timer #(.W(24)) u_recal_tmr (.ref_clk(ref_clk), .rst_b(rst_b), .t(recal_t));
  assign recal_min = 16'(RECAL_MIN_CYC);
  // [RULE15] pulse width window
  pulse_qualifier #(.W(16)) u_recal (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .level      (ctl[6] && (variant != VAR_EMBEDDED || RECAL_MIN_CYC > 0)),
    .min_cycles ((variant == VAR_EMBEDDED) ? fclr_min : recal_min),
    .max_cycles (16'(RECAL_MAX_CYC)),
    .reached    (),
    .ended      (recal_go)
  );
  assign recal_t.start = recal_go && (variant == VAR_EMBEDDED);
  assign recal_t.load  = 24'(RECAL_LIMIT);

  // [RULE16] embedded recalibrate bounded
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      recal_busy_q <= 1'b0;
    end else if (recal_t.start) begin
      recal_busy_q <= 1'b1;
    end else if (s_home || !recal_t.busy) begin
      recal_busy_q <= 1'b0;
    end
  end

  // ==========================================================
  // Channel reservation
  owner_type   own_q;
  logic        prio_q;
  logic [3:0]  since_q;
  logic        owner_sel;
  logic        owner_sel_q;
  logic        release_hit;
  logic        grant_pa;
  logic        grant_pb;
  timer_if #(.W(24)) rsv_t ();
  interval_timer #(.W(24)) u_rsv (.ref_clk(ref_clk), .rst_b(rst_b), .t(rsv_t));

  assign owner_sel = (own_q == OWN_A) ? s_sel_a : (own_q == OWN_B) ? s_sel_b : 1'b0;
  // [RULE21] priority needs both enabled
  assign grant_pa = dual_chan && s_pri_a && s_en_a && s_en_b && !(prio_q && own_q == OWN_B);
  assign grant_pb = dual_chan && s_pri_b && s_en_a && s_en_b && !(prio_q && own_q == OWN_A) && !grant_pa;
  // [RULE20] release honoured after minimum
  assign release_hit = dual_chan && ctl[9] && owner_sel && (since_q >= 4'(RELEASE_MIN_CYC));
  // [RULE19] timer started at deselection
  assign rsv_t.start = timer_en && owner_sel_q && !owner_sel && !prio_q;
  assign rsv_t.load  = 24'(RESERVE_HOLD);

  logic rsv_busy_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      own_q       <= OWN_NONE;
      prio_q      <= 1'b0;
      since_q     <= 4'h0;
      owner_sel_q <= 1'b0;
      rsv_busy_q  <= 1'b0;
    end else begin
      owner_sel_q <= owner_sel;
      rsv_busy_q  <= rsv_t.busy;
      if (since_q != 4'hF) begin
        since_q <= since_q + 4'h1;
      end
      case (own_q)
        OWN_NONE: begin
          // [RULE20] selection reserves at once
          if (s_sel_a || grant_pa) begin
            own_q   <= OWN_A;
            since_q <= 4'h0;
          end else if (s_sel_b || grant_pb) begin
            own_q   <= OWN_B;
            since_q <= 4'h0;
          end
        end
        OWN_A, OWN_B: begin
          // [RULE18] release clears both reserves
          if (release_hit) begin
            own_q  <= OWN_NONE;
            prio_q <= 1'b0;
          end else if (rsv_busy_q && !rsv_t.busy && !owner_sel && !prio_q) begin
            own_q <= OWN_NONE;
          end else if (!dual_chan && !owner_sel && !timer_en) begin
            own_q <= OWN_NONE;
          end
        end
        default: own_q <= OWN_NONE;
      endcase
      if (grant_pa && !(prio_q && own_q == OWN_A)) begin
        own_q   <= OWN_A;
        prio_q  <= 1'b1;
        since_q <= 4'h0;
      end else if (grant_pb && !(prio_q && own_q == OWN_B)) begin
        own_q   <= OWN_B;
        prio_q  <= 1'b1;
        since_q <= 4'h0;
      end
    end
  end

  // ==========================================================
  // Sector pulse generation and address mark search
  logic [SECTOR_PRESET_W-1:0] sect_cnt_q;
  logic [5:0]                 sect_num_q;
  logic                       sect_hold_q;
  logic [1:0]                 gap_q;
  logic                       sect_due;
  logic                       sect_allowed;

  assign sect_due = sclk_edge && (sect_cnt_q == preset_q);
  // [RULE24] cap at 63 per revolution
  assign sect_allowed = ((variant != VAR_CARTRIDGE && variant != VAR_EMBEDDED) ||
                         (sect_num_q < 6'(SECTORS_PER_REV))) && !sect_hold_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sect_cnt_q  <= '0;
      sect_num_q  <= 6'h00;
      sect_hold_q <= 1'b0;
    end else begin
      if (index_edge) begin
        sect_cnt_q  <= '0;
        sect_num_q  <= 6'h00;
        sect_hold_q <= 1'b0;
      // [RULE22] reset costs one clock
      end else if (sect_due) begin
        sect_cnt_q <= '0;
        if (sect_num_q != 6'h3F) begin
          sect_num_q <= sect_num_q + 6'h01;
        end
      end else if (sclk_edge) begin
        sect_cnt_q <= sect_cnt_q + 1'b1;
      end
      // [RULE25] volume change holds sectors
      if (vol_edge && variant == VAR_CARTRIDGE) begin
        sect_hold_q <= 1'b1;
      end
    end
  end

  // [RULE13] gap length in servo clocks
  // [RULE23] twelve bits per clock
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      gap_q <= 2'b00;
    end else if (!(ctl[1] && ctl[5] && !s_rdsig) || variant == VAR_EMBEDDED) begin
      gap_q <= 2'b00;
    end else if (sclk_edge && gap_q != 2'(MARK_GAP_SCLK)) begin
      gap_q <= gap_q + 2'b01;
    end
  end

  assign status_word = {16'h0, 2'b00, sect_num_q, own_q, prio_q, recal_busy_q,
                        hold_t.busy, wfault_q, fault_q, on_track};

  // ==========================================================
  // Registered pin outputs
  logic phys_offset;
  assign phys_offset = (variant == VAR_PHYSICAL) || (variant == VAR_CARTRIDGE);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      write_enable          <= 1'b0;
      read_enable           <= 1'b0;
      rd_q                  <= 1'b0;
      read_sync_start       <= 1'b0;
      offset_toward_spindle <= 1'b0;
      offset_away_spindle   <= 1'b0;
      on_track              <= 1'b0;
      fault                 <= 1'b0;
      write_fault           <= 1'b0;
      mark_erase            <= 1'b0;
      mark_found            <= 1'b0;
      strobe_early          <= 1'b0;
      strobe_late           <= 1'b0;
      recalibrate_home      <= 1'b0;
      head_reset            <= 1'b0;
      volume_select         <= 1'b0;
      seek_error_clear      <= 1'b0;
      unit_selected_a       <= 1'b0;
      unit_selected_b       <= 1'b0;
      busy_a                <= 1'b0;
      busy_b                <= 1'b0;
      sector_pulse          <= 1'b0;
    end else begin
      // [RULE2] write and read enables
      write_enable    <= ctl[0] && !fault_q;
      read_enable     <= ctl[1];
      rd_q            <= ctl[1];
      read_sync_start <= ctl[1] && !rd_q;
      // [RULE4] physical offset drive
      offset_toward_spindle <= phys_offset && ctl[2];
      offset_away_spindle   <= phys_offset && ctl[3];
      on_track    <= !hold_t.busy && !recal_busy_q;
      fault       <= fault_q;
      write_fault <= wfault_q;
      mark_erase  <= erase_now && !fault_q;
      mark_found  <= (gap_q == 2'(MARK_GAP_SCLK));
      // [RULE17] strobe shift only while reading
      strobe_early <= ctl[7] && ctl[1];
      strobe_late  <= ctl[8] && ctl[1];
      recalibrate_home <= recal_go;
      head_reset       <= recal_go;
      volume_select    <= recal_go && (variant == VAR_CARTRIDGE || variant == VAR_EMBEDDED);
      seek_error_clear <= recal_go;
      // [RULE21] opposite channel fully suppressed
      unit_selected_a <= s_sel_a && own_q == OWN_A;
      unit_selected_b <= s_sel_b && own_q == OWN_B;
      busy_a          <= s_sel_a && own_q == OWN_B && !prio_q;
      busy_b          <= s_sel_b && own_q == OWN_A && !prio_q;
      sector_pulse    <= sect_due && !index_edge && sect_allowed;
    end
  end

endmodule : disk_tag_logic

//--- sim/disk_tag_sva.sv
// Concurrent checks on the drive tag logic outputs.
`timescale 1ns/1ps
module disk_tag_sva (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic read_sync_start,
  input wire logic read_enable,
  input wire logic write_enable,
  input wire logic fault,
  input wire logic write_fault,
  input wire logic strobe_early,
  input wire logic strobe_late,
  input wire logic mark_erase,
  input wire logic offset_toward_spindle,
  input wire logic on_track,
  input wire logic recalibrate_home,
  input wire logic head_reset,
  input wire logic sector_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Output relations
  a_sync_one_cycle: assert property (read_sync_start |=> !read_sync_start) else $error("sync pulse long");
  a_fault_stops_write: assert property (fault && $past(fault) |-> !write_enable) else $error("fault write");
  a_strobe_needs_read: assert property (strobe_early || strobe_late |-> read_enable) else $error("no read");
  a_erase_needs_write: assert property (mark_erase |-> write_enable) else $error("erase without write");
  a_recal_with_head: assert property (
    recalibrate_home |-> head_reset ##1 !recalibrate_home) else $error("recal");
  a_sector_one_cycle: assert property (sector_pulse |=> !sector_pulse) else $error("sector pulse long");
  a_wfault_in_fault: assert property (write_fault |-> fault) else $error("write fault alone");
  a_offset_off_track: assert property (
    $rose(offset_toward_spindle) |-> ##[0:3] !on_track) else $error("track");
  c_sector: cover property (sector_pulse);
  c_recal: cover property (recalibrate_home);
  c_wfault: cover property (write_fault);
endmodule : disk_tag_sva
bind disk_tag_logic disk_tag_sva u_disk_tag_sva (.*);

//--- sim/ctrl_tag_model.sv
// Controller-side model that drives the control tag and bus lines.
`timescale 1ns/1ps
module ctrl_tag_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [9:0] op_bits,
  output logic            control_select,
  output logic [9:0]      bus_bits
);
  initial control_select = 1'b0;
  initial bus_bits = 10'h000;
  // read bits land with tag
  // Released lines flip every cycle so a drive that ignores the tag sees noise.
  always @(posedge ref_clk) begin
    control_select <= go;
    bus_bits <= go ? op_bits : ~bus_bits;
  end
endmodule : ctrl_tag_model

//--- sim/disk_tag_logic_tb_top.sv
// Self-checking bench for the drive tag and sector logic.
`timescale 1ns/1ps
module disk_tag_logic_tb_top;
  import disk_tag_pkg::*;
  typedef struct packed {logic [9:0] b; logic [4:0] e;} row_type;
  row_type     rows [6] = '{'{10'h001, 5'h01}, '{10'h002, 5'h02}, '{10'h082, 5'h06},
                            '{10'h102, 5'h0A}, '{10'h021, 5'h11}, '{10'h080, 5'h00}};
  logic        ref_clk = 1'b0, rst_b = 1'b0, go = 1'b0, srv = 1'b0, fc = 1'b0;
  logic        rd = 1'b0, wr = 1'b0, wt, cs;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, got;
  logic [9:0]  ob = 10'h000, bb;
  logic [10:0] p = 11'h000;
  logic [11:0] o;
  int          bad_count = 0, samples_checked = 0, rc = 0, sc = 0;
  // ==========================================================
  // Design, controller model and clock
  disk_tag_logic #(.OFFSET_HOLD(20), .EMB_HOLD(16), .RESERVE_HOLD(50), .RECAL_LIMIT(40)) u_disk_tag_logic (
    .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wt), .control_select(cs), .bus_bits(bb), .index_pin(p[0]),
    .servo_clk_pin(srv), .volume_change_tag(p[1]), .select_a(p[2]), .select_b(p[3]), .priority_a(p[4]),
    .priority_b(p[5]), .enable_a(p[6]), .enable_b(p[7]), .fault_condition(fc), .write_fault_condition(p[8]),
    .read_signal_present(p[9]), .home_reached(p[10]), .write_enable(o[0]), .read_enable(o[1]),
    .read_sync_start(), .offset_toward_spindle(o[5]), .offset_away_spindle(), .on_track(o[6]), .fault(o[7]),
    .write_fault(o[8]), .mark_erase(o[4]), .mark_found(), .strobe_early(o[2]), .strobe_late(o[3]),
    .recalibrate_home(o[9]), .head_reset(), .volume_select(), .seek_error_clear(), .unit_selected_a(o[11]),
    .unit_selected_b(), .busy_a(), .busy_b(), .sector_pulse(o[10]));
  ctrl_tag_model u_ctrl_tag_model (.ref_clk(ref_clk), .go(go), .op_bits(ob), .control_select(cs), .bus_bits(bb));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) rc <= rc + 32'(o[9] === 1'b1);
  always @(posedge ref_clk) sc <= sc + 32'(o[10] === 1'b1);
  // ==========================================================
  // Tasks
  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge ref_clk);
    end while (wt !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic up(input logic [9:0] b, input int n);
    @(posedge ref_clk);
    go <= 1'b1;
    ob <= b;
    repeat (n) @(posedge ref_clk);
  endtask : up
  // Eight idle cycles cover the pin synchronisers and the registered outputs.
  task automatic down;
    go <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : down
  // ==========================================================
  // Sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, ADDR_PRESET, 32'h0);
    chk(got, {20'h0, PRESET_RESET});
    bus(1'b0, 4'hC, 32'h0);
    chk(got, 32'h0);
    foreach (rows[i]) begin
      up(rows[i].b, 6);
      chk(32'(o[4:0]), 32'(rows[i].e));
      down();
    end
    up(10'h004, 6);
    chk(32'(o[6:5]), 32'h1);
    down();
    repeat (20) @(posedge ref_clk);
    chk(32'(o[6:5]), 32'h2);
    bus(1'b1, ADDR_CTRL, 32'h3);
    up(10'h004, 4);
    up(10'h005, 6);
    down();
    chk(32'(o[8:7]), 32'h3);
    fc <= 1'b1;
    up(10'h010, 4);
    down();
    chk(32'(o[7]), 32'h1);
    fc <= 1'b0;
    up(10'h010, 1);
    down();
    chk(32'(o[8:7]), 32'h3);
    up(10'h010, 4);
    down();
    chk(32'(o[8:7]), 32'h0);
    up(10'h040, 2);
    down();
    chk(rc, 32'h0);
    up(10'h040, 8);
    down();
    chk(rc, 32'h1);
    bus(1'b1, ADDR_PRESET, 32'h3);
    repeat (40) begin
      repeat (4) @(posedge ref_clk);
      srv <= 1'b1;
      repeat (4) @(posedge ref_clk);
      srv <= 1'b0;
    end
    repeat (10) @(posedge ref_clk);
    chk(sc, 32'hA);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(got, 32'h1);
    p[2] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(32'(o[11]), 32'h1);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : disk_tag_logic_tb_top
